// ===== inc/pmc_pkg.sv
// Register map, field layout, reset values and timing of the monitor bank.
package pmc_pkg;

    // ****************
    // Register map
    // ****************
    localparam logic [7:0]  PMC_SUPPLY_CFG_ADDR  = 8'h2B;   // Supply monitor configuration.
    localparam logic [7:0]  PMC_FET_CFG_ADDR     = 8'h2C;   // Drain-source and gate-source configuration.
    localparam logic [7:0]  PMC_SHUNT_CFG_ADDR   = 8'h2D;   // Shunt sense configuration.
    localparam logic [15:0] PMC_SUPPLY_CFG_RST   = 16'h4002; // Reset value of the supply register.
    localparam logic [15:0] PMC_FET_CFG_RST      = 16'h1101; // Reset value of the FET register.
    localparam logic [15:0] PMC_SHUNT_CFG_RST    = 16'h003B; // Reset value of the shunt register.
    localparam logic [15:0] PMC_SHUNT_CFG_MASK   = 16'h01FB; // Writable bits of the shunt register.

    // ****************
    // Field positions
    // ****************
    localparam int PMC_DRAIN_OV_LVL_LSB  = 14;  // Drain supply overvoltage level, two bits.
    localparam int PMC_DRAIN_RESP_BIT    = 13;  // Drain supply response.
    localparam int PMC_BST_OV_RESP_BIT   = 12;  // Bootstrap overvoltage response.
    localparam int PMC_BST_HOLD_BIT      = 11;  // Bootstrap low hold select.
    localparam int PMC_BST_LOW_RESP_BIT  = 10;  // Bootstrap low response.
    localparam int PMC_BST_LOW_LVL_BIT   = 9;   // Bootstrap low level.
    localparam int PMC_CORE_OV_RESP_BIT  = 8;   // Core supply overvoltage response.
    localparam int PMC_GATE_OV_RESP_BIT  = 7;   // Gate supply overvoltage response.
    localparam int PMC_GATE_LOW_RESP_BIT = 6;   // Gate supply low response.
    localparam int PMC_CP_OV_RESP_BIT    = 5;   // Charge pump overvoltage response.
    localparam int PMC_CP_LOW_RESP_BIT   = 4;   // Charge pump low response.
    localparam int PMC_PWR_LOW_LVL_BIT   = 3;   // Power supply low warning level.
    localparam int PMC_PWR_OV_LVL_LSB    = 1;   // Power supply overvoltage level, two bits.
    localparam int PMC_PWR_OV_RESP_BIT   = 0;   // Power supply overvoltage response.
    localparam int PMC_DS_RESP_LSB       = 14;  // Drain-source overcurrent response, two bits.
    localparam int PMC_DS_BLANK_LSB      = 11;  // Drain-source blanking, three bits.
    localparam int PMC_DS_FILTER_LSB     = 8;   // Drain-source filter, three bits.
    localparam int PMC_GS_RESP_LSB       = 6;   // Gate-source response, two bits.
    localparam int PMC_GS_BLANK_LSB      = 3;   // Gate-source blanking, three bits.
    localparam int PMC_GS_FILTER_LSB     = 0;   // Gate-source filter, three bits.
    localparam int PMC_GS_LEVEL_BIT      = 8;   // Gate-source level.
    localparam int PMC_SHUNT_RESP_LSB    = 6;   // Shunt overcurrent response, two bits.
    localparam int PMC_SHUNT_THR_LSB     = 3;   // Shunt overcurrent threshold, three bits.
    localparam int PMC_SHUNT_FILT_LSB    = 0;   // Shunt overcurrent filter, two bits.

    // ****************
    // Monitor indices and timing
    // ****************
    localparam int PMC_NMON      = 13;  // Number of monitored events.
    localparam int PMC_M_DRAIN_LOW = 0;
    localparam int PMC_M_DRAIN_OV  = 1;
    localparam int PMC_M_BST_OV    = 2;
    localparam int PMC_M_BST_LOW   = 3;
    localparam int PMC_M_CORE_OV   = 4;
    localparam int PMC_M_GATE_OV   = 5;
    localparam int PMC_M_GATE_LOW  = 6;
    localparam int PMC_M_CP_OV     = 7;
    localparam int PMC_M_CP_LOW    = 8;
    localparam int PMC_M_PWR_OV    = 9;
    localparam int PMC_M_DS_OC     = 10;
    localparam int PMC_M_GS        = 11;
    localparam int PMC_M_SHUNT     = 12;
    localparam int PMC_CLK_PERIOD_NS = 100;   // System clock period.
    localparam int PMC_SHUNT_FILT0_NS = 2000;  // Shunt filter time, code 00.
    localparam int PMC_SHUNT_FILT1_NS = 4000;  // Shunt filter time, code 01.
    localparam int PMC_SHUNT_FILT2_NS = 6000;  // Shunt filter time, code 10.
    localparam int PMC_SHUNT_FILT3_NS = 10000; // Shunt filter time, code 11.
    localparam logic [6:0] PMC_SHUNT_FILT0_CYC = 7'(PMC_SHUNT_FILT0_NS / PMC_CLK_PERIOD_NS);
    localparam logic [6:0] PMC_SHUNT_FILT1_CYC = 7'(PMC_SHUNT_FILT1_NS / PMC_CLK_PERIOD_NS);
    localparam logic [6:0] PMC_SHUNT_FILT2_CYC = 7'(PMC_SHUNT_FILT2_NS / PMC_CLK_PERIOD_NS);
    localparam logic [6:0] PMC_SHUNT_FILT3_CYC = 7'(PMC_SHUNT_FILT3_NS / PMC_CLK_PERIOD_NS);

    // Response of one monitor: report sets the flag, shutdown also trips the fault path.
    typedef struct packed {
        logic report;
        logic shutdown;
    } pmc_resp_s;

endpackage : pmc_pkg

// ===== rtl/pmc_top.sv
// Monitor configuration bank with response logic.
`timescale 1ns/1ps
// How it works
// - Drain overvoltage level 00/01/1x, reset 01.
// - Bit 13 sets drain supply both-monitor response.
// - Bit 12 sets bootstrap overvoltage response.
// - Hold off: bootstrap low flag follows condition.
// - Hold on: bootstrap low flag latches.
// - Bit 10 sets latched bootstrap low response.
// - Bit 9 picks 4.2V or 7.2V.
// - Bit 8 sets core supply overvoltage response.
// - Bit 7 sets gate supply overvoltage response.
// - Bit 5 sets charge pump overvoltage response.
// - Bit 4 sets charge pump low response.
// - Power low level bit 3, overvoltage level 2-1.
// - Bit 0 sets power supply overvoltage response.
// - Drain-source response: warn, fault, reserved, none.
// - Drain-source blanking 13-11, filter 10-8.
// - Gate-source response: warn, fault, reserved, none.
// - Gate-source blanking 5-3, filter 2-0.
// - Shunt response: warn, fault, reserved, none.
// - Shunt threshold codes map 50 to 500 mV.
// - Shunt filter 2, 4, 6, 10 us.
module pmc_top (
    // Clock and reset.
    input  wire logic                          clock,
    input  wire logic                          arst_n,
    // Register port from the serial configuration framer.
    input  wire logic                          reg_wr_en,
    input  wire logic                          reg_rd_en,
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [15:0]                   reg_wdata,
    output logic      [15:0]                   reg_rdata,
    // Raw comparator conditions, one per monitor.
    input  wire logic [pmc_pkg::PMC_NMON-1:0]  mon_cond,
    // Flag clear mask, one-cycle pulse per bit.
    input  wire logic [pmc_pkg::PMC_NMON-1:0]  flag_clear,
    // Status and fault outputs.
    output logic      [pmc_pkg::PMC_NMON-1:0]  mon_flags,
    output logic                               fault_n,
    output logic                               gate_shutdown,
    // Configuration outputs to the analog monitors.
    output logic      [15:0]                   supply_monitor_config,
    output logic      [15:0]                   fet_monitor_config,
    output logic      [15:0]                   shunt_monitor_config,
    output logic      [15:0]                   drain_ov_threshold_mv,
    output logic      [15:0]                   bootstrap_low_threshold_mv,
    output logic      [9:0]                    shunt_threshold_mv
);
    import pmc_pkg::*;

    // ****************
    // Helper functions
    // ****************

    // Maps a one-bit mode onto a response: zero warns, one faults.
    function automatic pmc_resp_s resp1(input logic mode);
        pmc_resp_s r;
        r.report   = 1'b1;
        r.shutdown = mode;
        return r;
    endfunction : resp1

    // Maps a two-bit mode; the reserved code acts as a warning.
    function automatic pmc_resp_s resp2(input logic [1:0] mode);
        pmc_resp_s r;
        r.report   = (mode != 2'h3);
        r.shutdown = (mode == 2'h1);
        return r;
    endfunction : resp2

    // ****************
    // State
    // ****************

    // All module state in one record.
    typedef struct packed {
        logic [15:0]         supply_cfg;   // Supply monitor register.
        logic [15:0]         fet_cfg;      // FET monitor register.
        logic [15:0]         shunt_cfg;    // Shunt monitor register.
        logic [PMC_NMON-1:0] sync1;        // First synchroniser stage.
        logic [PMC_NMON-1:0] sync2;        // Second synchroniser stage.
        logic [PMC_NMON-1:0] flags;        // Reported flags.
        logic [PMC_NMON-1:0] faults;       // Latched fault causes.
        logic [6:0]          shunt_cnt;    // Shunt filter counter.
        logic [15:0]         rdata;        // Read data.
        logic                fault_n;      // Fault output, low active.
        logic                shutdown;     // Gate driver shutdown.
        logic [15:0]         drain_mv;     // Drain overvoltage threshold.
        logic [15:0]         bst_mv;       // Bootstrap low threshold.
        logic [9:0]          shunt_mv;     // Shunt threshold.
    } pmc_state_s;

    pmc_state_s state_ff;   // Registered state.
    pmc_state_s nxt_state;  // Next state.

    pmc_resp_s  resp [PMC_NMON];      // Response of each monitor.
    logic [PMC_NMON-1:0] events;      // Qualified event per monitor.
    logic [6:0]          shunt_need;  // Cycles the shunt condition must persist.

    // ****************
    // Response decode
    // ****************

    // Decodes each monitor response from the stored fields.
    always_comb begin
        resp[PMC_M_DRAIN_LOW] = resp1(state_ff.supply_cfg[PMC_DRAIN_RESP_BIT]);
        resp[PMC_M_DRAIN_OV]  = resp1(state_ff.supply_cfg[PMC_DRAIN_RESP_BIT]);
        resp[PMC_M_BST_OV]    = resp1(state_ff.supply_cfg[PMC_BST_OV_RESP_BIT]);
        // The low response only applies while the bootstrap flag is held.
        if (state_ff.supply_cfg[PMC_BST_HOLD_BIT]) begin
            resp[PMC_M_BST_LOW] = resp1(state_ff.supply_cfg[PMC_BST_LOW_RESP_BIT]);
        end else begin
            resp[PMC_M_BST_LOW] = resp1(1'b0);
        end
        resp[PMC_M_CORE_OV]   = resp1(state_ff.supply_cfg[PMC_CORE_OV_RESP_BIT]);
        resp[PMC_M_GATE_OV]   = resp1(state_ff.supply_cfg[PMC_GATE_OV_RESP_BIT]);
        resp[PMC_M_GATE_LOW]  = resp1(state_ff.supply_cfg[PMC_GATE_LOW_RESP_BIT]);
        resp[PMC_M_CP_OV]     = resp1(state_ff.supply_cfg[PMC_CP_OV_RESP_BIT]);
        resp[PMC_M_CP_LOW]    = resp1(state_ff.supply_cfg[PMC_CP_LOW_RESP_BIT]);
        resp[PMC_M_PWR_OV]    = resp1(state_ff.supply_cfg[PMC_PWR_OV_RESP_BIT]);
        resp[PMC_M_DS_OC]     = resp2(state_ff.fet_cfg[PMC_DS_RESP_LSB +: 2]);
        resp[PMC_M_GS]        = resp2(state_ff.fet_cfg[PMC_GS_RESP_LSB +: 2]);
        resp[PMC_M_SHUNT]     = resp2(state_ff.shunt_cfg[PMC_SHUNT_RESP_LSB +: 2]);
    end

    // Selects the shunt filter length from the current setting.
    always_comb begin
        case (state_ff.shunt_cfg[PMC_SHUNT_FILT_LSB +: 2])
            2'h0:    shunt_need = PMC_SHUNT_FILT0_CYC;
            2'h1:    shunt_need = PMC_SHUNT_FILT1_CYC;
            2'h2:    shunt_need = PMC_SHUNT_FILT2_CYC;
            default: shunt_need = PMC_SHUNT_FILT3_CYC;
        endcase
    end

    // Events are the synchronised conditions; the shunt one must outlast its filter.
    always_comb begin
        events              = state_ff.sync2;
        events[PMC_M_SHUNT] = state_ff.sync2[PMC_M_SHUNT] && (state_ff.shunt_cnt >= shunt_need);
    end

    // ****************
    // Next state
    // ****************

    // Computes writes, reads, flags, faults and thresholds.
    always_comb begin
        nxt_state       = state_ff;
        nxt_state.sync1 = mon_cond;
        nxt_state.sync2 = state_ff.sync1;

        // Register writes take effect on the next cycle.
        if (reg_wr_en) begin
            case (reg_addr)
                PMC_SUPPLY_CFG_ADDR: nxt_state.supply_cfg = reg_wdata;
                PMC_FET_CFG_ADDR:    nxt_state.fet_cfg    = reg_wdata;
                PMC_SHUNT_CFG_ADDR:  nxt_state.shunt_cfg  = reg_wdata & PMC_SHUNT_CFG_MASK;
                default: begin
                end
            endcase
        end

        // Reads return the stored value; unmapped addresses read zero.
        if (reg_rd_en) begin
            case (reg_addr)
                PMC_SUPPLY_CFG_ADDR: nxt_state.rdata = state_ff.supply_cfg;
                PMC_FET_CFG_ADDR:    nxt_state.rdata = state_ff.fet_cfg;
                PMC_SHUNT_CFG_ADDR:  nxt_state.rdata = state_ff.shunt_cfg & PMC_SHUNT_CFG_MASK;
                default:             nxt_state.rdata = 16'h0000;
            endcase
        end

        // The shunt filter counts while the condition holds and saturates.
        if (!state_ff.sync2[PMC_M_SHUNT]) begin
            nxt_state.shunt_cnt = 7'h00;
        end else if (state_ff.shunt_cnt < PMC_SHUNT_FILT3_CYC) begin
            nxt_state.shunt_cnt = state_ff.shunt_cnt + 7'h01;
        end

        // Sticky flags and fault causes; a new event wins over a clear.
        for (int i = 0; i < PMC_NMON; i++) begin
            if (flag_clear[i]) begin
                nxt_state.flags[i]  = 1'b0;
                nxt_state.faults[i] = 1'b0;
            end
            if (events[i] && resp[i].report) begin
                nxt_state.flags[i] = 1'b1;
            end
            if (events[i] && resp[i].shutdown) begin
                nxt_state.faults[i] = 1'b1;
            end
        end

        // Bootstrap low flag follows the synchronised condition when not held.
        if (!state_ff.supply_cfg[PMC_BST_HOLD_BIT]) begin
            nxt_state.flags[PMC_M_BST_LOW]  = state_ff.sync2[PMC_M_BST_LOW];
            nxt_state.faults[PMC_M_BST_LOW] = 1'b0;
        end else if (events[PMC_M_BST_LOW]) begin
            nxt_state.flags[PMC_M_BST_LOW]  = 1'b1;
        end

        // Any latched fault cause asserts the fault pin and stops the drivers.
        nxt_state.fault_n  = ~(|nxt_state.faults);
        nxt_state.shutdown = |nxt_state.faults;

        // Drain supply overvoltage threshold; both upper codes give 53.5V.
        case (nxt_state.supply_cfg[PMC_DRAIN_OV_LVL_LSB +: 2])
            2'h0:    nxt_state.drain_mv = 16'h733C;
            2'h1:    nxt_state.drain_mv = 16'h86C4;
            default: nxt_state.drain_mv = 16'hD0FC;
        endcase

        // Bootstrap low threshold, 4.2V or 7.2V.
        if (nxt_state.supply_cfg[PMC_BST_LOW_LVL_BIT]) begin
            nxt_state.bst_mv = 16'h1C20;
        end else begin
            nxt_state.bst_mv = 16'h1068;
        end

        // Shunt overcurrent threshold in millivolts.
        case (nxt_state.shunt_cfg[PMC_SHUNT_THR_LSB +: 3])
            3'h0:    nxt_state.shunt_mv = 10'h032;
            3'h1:    nxt_state.shunt_mv = 10'h04B;
            3'h2:    nxt_state.shunt_mv = 10'h064;
            3'h3:    nxt_state.shunt_mv = 10'h07D;
            3'h4:    nxt_state.shunt_mv = 10'h096;
            3'h5:    nxt_state.shunt_mv = 10'h0C8;
            3'h6:    nxt_state.shunt_mv = 10'h12C;
            default: nxt_state.shunt_mv = 10'h1F4;
        endcase
    end

    // ****************
    // State register
    // ****************

    // Registers the whole state; reset loads the power-on defaults.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff            <= '0;
            state_ff.supply_cfg <= PMC_SUPPLY_CFG_RST;
            state_ff.fet_cfg    <= PMC_FET_CFG_RST;
            state_ff.shunt_cfg  <= PMC_SHUNT_CFG_RST;
            state_ff.fault_n    <= 1'b1;
            state_ff.drain_mv   <= 16'h86C4;
            state_ff.bst_mv     <= 16'h1068;
            state_ff.shunt_mv   <= 10'h1F4;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************
    // Outputs
    // ****************

    // Every output is a field of the state register.
    assign reg_rdata                  = state_ff.rdata;
    assign mon_flags                  = state_ff.flags;
    assign fault_n                    = state_ff.fault_n;
    assign gate_shutdown              = state_ff.shutdown;
    assign supply_monitor_config      = state_ff.supply_cfg;
    assign fet_monitor_config         = state_ff.fet_cfg;
    assign shunt_monitor_config       = state_ff.shunt_cfg;
    assign drain_ov_threshold_mv      = state_ff.drain_mv;
    assign bootstrap_low_threshold_mv = state_ff.bst_mv;
    assign shunt_threshold_mv         = state_ff.shunt_mv;

endmodule : pmc_top

// ===== tb/pmc_properties.sv
// Concurrent properties of the monitor configuration bank.
`timescale 1ns/1ps
module pmc_checker
    import pmc_pkg::*;
(
    // Clock and reset.
    input wire logic                         clock,
    input wire logic                         arst_n,
    // Register port.
    input wire logic                         reg_wr_en,
    input wire logic                         reg_rd_en,
    input wire logic [7:0]                   reg_addr,
    input wire logic [15:0]                  reg_wdata,
    input wire logic [15:0]                  reg_rdata,
    // Monitor path.
    input wire logic [pmc_pkg::PMC_NMON-1:0] mon_cond,
    input wire logic [pmc_pkg::PMC_NMON-1:0] flag_clear,
    input wire logic [pmc_pkg::PMC_NMON-1:0] mon_flags,
    input wire logic                         fault_n,
    input wire logic                         gate_shutdown,
    // Configuration outputs.
    input wire logic [15:0]                  supply_monitor_config,
    input wire logic [15:0]                  fet_monitor_config,
    input wire logic [15:0]                  shunt_monitor_config,
    input wire logic [15:0]                  drain_ov_threshold_mv,
    input wire logic [15:0]                  bootstrap_low_threshold_mv,
    input wire logic [9:0]                   shunt_threshold_mv
);
    // Shunt threshold in millivolts for each code.
    localparam logic [9:0] SHUNT_MV [8] = '{10'h032, 10'h04B, 10'h064, 10'h07D, 10'h096, 10'h0C8, 10'h12C, 10'h1F4};
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // Power overvoltage newly seen and held with fault response chosen.
    sequence pwr_ov_held;
        $rose(mon_cond[PMC_M_PWR_OV]) ##0 (mon_cond[PMC_M_PWR_OV] && supply_monitor_config[0])[*5];
    endsequence
    // Drain-source condition held with the silent code.
    sequence ds_quiet_held;
        !mon_flags[PMC_M_DS_OC] ##0 (mon_cond[PMC_M_DS_OC] && fet_monitor_config[15:14] == 2'h3)[*5];
    endsequence
    pwr_fault_trip_a: assert property (pwr_ov_held |=> !fault_n && gate_shutdown && mon_flags[PMC_M_PWR_OV])
        else $error("power fault did not trip");
    shutdown_pair_a: assert property (gate_shutdown == !fault_n)
        else $error("shutdown and fault pin disagree");
    fault_cause_a: assert property (!fault_n |-> mon_flags != '0)
        else $error("fault without a flag");
    flag_clear_a: assert property ((!mon_cond[9])[*3] ##0 flag_clear[9] |=> !mon_flags[9])
        else $error("flag not cleared");
    wr_supply_a: assert property (reg_wr_en && reg_addr == 8'h2B |=> supply_monitor_config == $past(reg_wdata))
        else $error("supply write not applied");
    shunt_mask_a: assert property ((shunt_monitor_config & 16'hFE04) == 16'h0000)
        else $error("reserved shunt bits set");
    rd_fet_a: assert property (reg_rd_en && reg_addr == 8'h2C |=> reg_rdata == $past(fet_monitor_config))
        else $error("wrong read data");
    rd_unmapped_a: assert property (reg_rd_en && !(reg_addr inside {[8'h2B:8'h2D]}) |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    drain_thr_a: assert property (drain_ov_threshold_mv == (supply_monitor_config[15] ? 16'hD0FC :
        supply_monitor_config[14] ? 16'h86C4 : 16'h733C))
        else $error("drain threshold wrong");
    bst_thr_a: assert property (bootstrap_low_threshold_mv == (supply_monitor_config[9] ? 16'h1C20 : 16'h1068))
        else $error("bootstrap threshold wrong");
    shunt_thr_a: assert property (shunt_threshold_mv == SHUNT_MV[shunt_monitor_config[5:3]])
        else $error("shunt threshold wrong");
    ds_quiet_a: assert property (ds_quiet_held |=> !mon_flags[PMC_M_DS_OC])
        else $error("silent response reported");
    bst_follow_a: assert property ((!supply_monitor_config[11] && !mon_cond[3])[*4] |=> !mon_flags[3])
        else $error("bootstrap flag did not follow");
    bst_hold_a: assert property (supply_monitor_config[11] && mon_flags[3] && !flag_clear[3] |=> mon_flags[3])
        else $error("bootstrap flag not held");
endmodule : pmc_checker

bind pmc_top pmc_checker chk_u (
    .clock(clock), .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mon_cond(mon_cond), .flag_clear(flag_clear),
    .mon_flags(mon_flags), .fault_n(fault_n), .gate_shutdown(gate_shutdown),
    .supply_monitor_config(supply_monitor_config), .fet_monitor_config(fet_monitor_config),
    .shunt_monitor_config(shunt_monitor_config), .drain_ov_threshold_mv(drain_ov_threshold_mv),
    .bootstrap_low_threshold_mv(bootstrap_low_threshold_mv), .shunt_threshold_mv(shunt_threshold_mv)
);

// ===== tb/pmc_host.sv
// Host model driving the register port of the bank.
`timescale 1ns/1ps
module pmc_host (
    // Clock.
    input  wire logic        clock,
    // Register port toward the bank.
    output logic             reg_wr_en,
    output logic             reg_rd_en,
    output logic [7:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    // Idle port at time zero.
    initial {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
    // One write; released data shows the inverse.
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
        @(posedge clock);
        reg_wr_en <= 1'h1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge clock);
        reg_wr_en <= 1'h0;
        reg_wdata <= ~data;
        #1;
    endtask : write_reg
    // One read; data is taken just after the strobe's edge.
    task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
        @(posedge clock);
        reg_rd_en <= 1'h1;
        reg_addr  <= addr;
        @(posedge clock);
        reg_rd_en <= 1'h0;
        reg_addr  <= ~addr;
        #1;
        data = reg_rdata;
    endtask : read_reg
endmodule : pmc_host

// ===== tb/test_protection_monitor_config.sv
// Self-checking bench of the monitor configuration bank.
`timescale 1ns/1ps
module test_protection_monitor_config;
    import pmc_pkg::*;
    // Clock, reset and port signals.
    logic        clock, arst_n, reg_wr_en, reg_rd_en, fault_n, gate_shutdown;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, sup_cfg, fet_cfg, shunt_cfg, drain_mv, bst_mv;
    logic [9:0]  shunt_mv;
    logic [12:0] mon_cond, flag_clear, mon_flags;
    int          num_errors, checks_done;
    pmc_host host_u (.clock(clock), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    pmc_top dut_u (.clock(clock), .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mon_cond(mon_cond),
        .flag_clear(flag_clear), .mon_flags(mon_flags), .fault_n(fault_n), .gate_shutdown(gate_shutdown),
        .supply_monitor_config(sup_cfg), .fet_monitor_config(fet_cfg), .shunt_monitor_config(shunt_cfg),
        .drain_ov_threshold_mv(drain_mv), .bootstrap_low_threshold_mv(bst_mv), .shunt_threshold_mv(shunt_mv));
    // Compares one value and counts it.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    // Prints the verdict and ends the run.
    task automatic close_out();
        if (num_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    // Sets one condition and waits for it to settle.
    task automatic set_cond(input int idx, input logic val);
        @(posedge clock) mon_cond[idx] <= val;
        repeat (30) @(posedge clock);
        #1;
    endtask : set_cond
    // Drops a condition, clears it and expects quiet.
    task automatic drop_clear(input int idx);
        set_cond(idx, 1'h0);
        @(posedge clock) flag_clear[idx] <= 1'h1;
        @(posedge clock) flag_clear[idx] <= 1'h0;
        #1;
        chk({1'h0, mon_flags, fault_n, gate_shutdown}, 16'h0002);
    endtask : drop_clear
    // Sets a response, raises the condition, judges flag and fault.
    task automatic mon_run(input int idx, input logic [7:0] addr, input logic [15:0] cfg, input logic ef, input logic eq);
        host_u.write_reg(addr, cfg);
        set_cond(idx, 1'h1);
        chk({13'h0, mon_flags[idx], fault_n, gate_shutdown}, {13'h0, ef, !eq, eq});
        drop_clear(idx);
    endtask : mon_run
    // Reset values, then writes, masked bits and unmapped places.
    task automatic t_regs();
        logic [15:0] d;
        host_u.read_reg(8'h2B, d);
        chk(d, 16'h4002);
        host_u.read_reg(8'h2C, d);
        chk(d, 16'h1101);
        host_u.read_reg(8'h2D, d);
        chk(d, 16'h003B);
        chk(drain_mv, 16'h86C4);
        host_u.write_reg(8'h2B, 16'hA5A5);
        host_u.write_reg(8'h2C, 16'h5A5A);
        host_u.write_reg(8'h2D, 16'hFFFF);
        host_u.write_reg(8'h2A, 16'h0000);
        host_u.read_reg(8'h2B, d);
        chk(d, 16'hA5A5);
        host_u.read_reg(8'h2C, d);
        chk(d, 16'h5A5A);
        host_u.read_reg(8'h2D, d);
        chk(d, 16'h01FB);
        host_u.read_reg(8'h2E, d);
        chk(d, 16'h0000);
    endtask : t_regs
    // Every threshold code against its voltage.
    task automatic t_levels();
        logic [9:0]  smv [8] = '{10'h032, 10'h04B, 10'h064, 10'h07D, 10'h096, 10'h0C8, 10'h12C, 10'h1F4};
        logic [15:0] dmv [4] = '{16'h733C, 16'h86C4, 16'hD0FC, 16'hD0FC};
        for (int c = 0; c < 8; c++) begin
            host_u.write_reg(8'h2D, 16'(c) << 3);
            chk({6'h0, shunt_mv}, {6'h0, smv[c]});
        end
        for (int c = 0; c < 4; c++) begin
            host_u.write_reg(8'h2B, (16'(c) << 14) | (16'(c % 2) << 9));
            chk(drain_mv, dmv[c]);
            chk(bst_mv, c % 2 ? 16'h1C20 : 16'h1068);
        end
    endtask : t_levels
    // Warning and fault for each supply monitor except bootstrap low, then all two-bit codes.
    task automatic t_responses();
        int mi [9] = '{0, 1, 2, 4, 5, 6, 7, 8, 9};
        int bi [9] = '{13, 13, 12, 8, 7, 6, 5, 4, 0};
        for (int i = 0; i < 9; i++) begin
            for (int r = 0; r < 2; r++) begin
                mon_run(mi[i], 8'h2B, 16'(r) << bi[i], 1'h1, r[0]);
            end
        end
        for (int c = 0; c < 4; c++) begin
            mon_run(10, 8'h2C, 16'(c) << 14, c != 3, c == 1);
            mon_run(11, 8'h2C, 16'(c) << 6, c != 3, c == 1);
            mon_run(12, 8'h2D, 16'(c) << 6, c != 3, c == 1);
        end
    endtask : t_responses
    // Shunt filter codes against their delay in cycles.
    task automatic t_filter();
        int f [4] = '{20, 40, 60, 100};
        int n;
        for (int c = 0; c < 4; c++) begin
            host_u.write_reg(8'h2D, 16'(c));
            @(posedge clock) mon_cond[12] <= 1'h1;
            n = 0;
            while (mon_flags[12] !== 1'h1 && n < 200) begin
                @(posedge clock);
                #1;
                n++;
            end
            if (n == 200) begin
                num_errors++;
                close_out();
            end
            chk(16'(n), 16'(f[c] + 3));
            drop_clear(12);
        end
    endtask : t_filter
    // Bootstrap low flag live, then held.
    task automatic t_bootstrap();
        host_u.write_reg(8'h2B, 16'h0400);
        set_cond(3, 1'h1);
        chk({14'h0, mon_flags[3], fault_n}, 16'h0003);
        set_cond(3, 1'h0);
        chk({15'h0, mon_flags[3]}, 16'h0000);
        host_u.write_reg(8'h2B, 16'h0C00);
        set_cond(3, 1'h1);
        set_cond(3, 1'h0);
        chk({14'h0, mon_flags[3], fault_n}, 16'h0002);
        drop_clear(3);
        mon_run(3, 8'h2B, 16'h0800, 1'h1, 1'h0);
    endtask : t_bootstrap
    // Free-running clock.
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    // Reset, scenarios and verdict.
    initial begin
        arst_n = 1'h0;
        mon_cond = '0;
        flag_clear = '0;
        num_errors = 0;
        checks_done = 0;
        repeat (8) @(posedge clock);
        arst_n <= 1'h1;
        t_regs();
        t_levels();
        t_responses();
        t_filter();
        t_bootstrap();
        close_out();
    end
endmodule : test_protection_monitor_config
